// [inc/psag_pkg.sv]
package psag_pkg;
	localparam int PSAG_ADDR_W = 24;
	localparam int PSAG_PC_W = 23;
	localparam int PSAG_WORD_W = 24;
	localparam int PSAG_DATA_W = 16;
	localparam int PSAG_PAGE_W = 8;
	localparam int PSAG_TOP_BIT = 23;
	localparam int PSAG_PAGE_TOP = 7;
	localparam int PSAG_VIS_EA_W = 15;
	localparam logic [23:0] PSAG_USER_MAX = 24'h7FFFFE;
	localparam logic [22:0] PSAG_PC_STEP = 23'h000002;
	localparam logic [22:0] PSAG_PC_RESET = 23'h000000;
	localparam logic [7:0] PSAG_PAGE_RESET = 8'h00;
	localparam logic [15:0] PSAG_VIS_BASE = 16'h8000;
	localparam int PSAG_VIS_PAGE_WORDS = 16384;
	localparam int PSAG_RD_LAT = 1;

	typedef enum logic [2:0] {
		PSAG_OP_NONE,
		PSAG_OP_FETCH,
		PSAG_OP_VIS,
		PSAG_OP_RD_LOW,
		PSAG_OP_RD_HIGH,
		PSAG_OP_WR_LOW,
		PSAG_OP_WR_HIGH
	} psag_op_t;
endpackage

// [inc/psag_lane_if.sv]
`timescale 1ns/100ps
interface psag_lane_if;
	import psag_pkg::*;
	logic [PSAG_WORD_W-1:0] word;
	logic high_sel;
	logic byte_mode;
	logic byte_sel;
	logic [PSAG_DATA_W-1:0] data;
	modport src (output word, output high_sel, output byte_mode, output byte_sel, input data);
	modport mux (input word, input high_sel, input byte_mode, input byte_sel, output data);
endinterface

// [hw/psag_lane_mux.sv]
`timescale 1ns/100ps
module psag_lane_mux
	import psag_pkg::*;
(
	psag_lane_if.mux lane
);
	wire [7:0] low_byte = lane.byte_sel ? lane.word[15:8] : lane.word[7:0];
	wire [7:0] high_byte = lane.byte_sel ? 8'h00 : lane.word[23:16];
	wire [15:0] low_res = lane.byte_mode ? {8'h00, low_byte} : lane.word[15:0];
	wire [15:0] high_res = lane.byte_mode ? {8'h00, high_byte} : {8'h00, lane.word[23:16]};
	// upper byte only ever reaches data through the high path
	assign lane.data = lane.high_sel ? high_res : low_res;
endmodule

// [hw/psag_top.sv]
`timescale 1ns/100ps
module psag_top
	import psag_pkg::*;
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// program counter control
	input wire logic pc_advance,
	input wire logic pc_load,
	input wire logic [22:0] pc_load_value,
	output logic [22:0] pc_out,
	// page registers
	input wire logic table_page_we,
	input wire logic [7:0] table_page_wdata,
	input wire logic visibility_page_we,
	input wire logic [7:0] visibility_page_wdata,
	input wire logic program_visibility_enable,
	output logic [7:0] table_page_reg,
	output logic [7:0] visibility_page_reg,
	// access request from the decoder
	input wire logic req_valid,
	input wire psag_op_t req_op,
	input wire logic [15:0] req_ea,
	input wire logic req_byte,
	// program memory side
	output logic [23:0] pm_addr,
	output logic pm_rd,
	output logic pm_config,
	input wire logic [23:0] pm_rdata,
	// flash programming hand-off
	output logic flash_wr_valid,
	output logic flash_wr_high,
	output logic [23:0] flash_wr_addr,
	output logic [15:0] flash_wr_data,
	input wire logic [15:0] req_wdata,
	// results
	output logic [23:0] instr_word,
	output logic instr_valid,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic addr_fault
);
	logic [22:0] pc_q, pc_d;
	logic [7:0] tpage_q, vpage_q;
	logic [23:0] addr_q;
	logic rd_q, cfg_q, fault_q;
	logic fw_valid_q, fw_high_q;
	logic [23:0] fw_addr_q;
	logic [15:0] fw_data_q;
	psag_op_t pend_q;
	logic pend_byte_q, pend_bsel_q;
	logic [23:0] instr_q;
	logic instr_v_q;
	logic [15:0] rdata_q;
	logic rd_v_q;

	// address construction per access kind
	wire [23:0] fetch_addr = {1'b0, pc_q[22:1], 1'b0};
	wire [23:0] table_addr = {tpage_q, req_ea};
	wire [23:0] vis_addr = {1'b0, vpage_q, req_ea[14:0]};
	wire is_table = (req_op == PSAG_OP_RD_LOW) || (req_op == PSAG_OP_RD_HIGH) ||
		(req_op == PSAG_OP_WR_LOW) || (req_op == PSAG_OP_WR_HIGH);
	wire is_write = (req_op == PSAG_OP_WR_LOW) || (req_op == PSAG_OP_WR_HIGH);
	// visibility only answers for the upper half of data space
	wire vis_hit = program_visibility_enable && req_ea[15];
	wire is_vis = (req_op == PSAG_OP_VIS) && vis_hit;
	wire [23:0] raw_addr = is_table ? table_addr : (is_vis ? vis_addr : fetch_addr);
	// bit 23 survives only on table accesses; byte select is ea bit 0 on table ops
	wire [23:0] eff_addr = is_table ? raw_addr : {1'b0, raw_addr[22:0]};
	// the word grain makes bit 0 a byte select, memory sees the even address
	wire [23:0] mem_addr = {eff_addr[23:1], 1'b0};
	// judged on the word address, so an odd ea on the top visibility word is still legal
	wire over_user = !is_table && (mem_addr > PSAG_USER_MAX);
	wire do_read = req_valid && !is_write && (req_op != PSAG_OP_NONE) &&
		!over_user && (req_op != PSAG_OP_VIS || vis_hit);
	wire do_flash = req_valid && is_write;
	wire is_high = (pend_q == PSAG_OP_RD_HIGH);

	psag_lane_if lane ();
	assign lane.word = pm_rdata;
	assign lane.high_sel = is_high;
	assign lane.byte_mode = pend_byte_q;
	assign lane.byte_sel = pend_bsel_q;
	psag_lane_mux u_lane (
		.lane(lane)
	);

	// program counter keeps word steps of two so it lines up with data addresses
	assign pc_d = pc_load ? {pc_load_value[22:1], 1'b0} : pc_q + PSAG_PC_STEP;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pc_q <= PSAG_PC_RESET;
			tpage_q <= PSAG_PAGE_RESET;
			vpage_q <= PSAG_PAGE_RESET;
		end else if (clk_en) begin
			if (pc_load || pc_advance) begin
				pc_q <= pc_d;
			end
			if (table_page_we) begin
				tpage_q <= table_page_wdata;
			end
			if (visibility_page_we) begin
				vpage_q <= visibility_page_wdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			addr_q <= 24'h000000;
			rd_q <= 1'b0;
			cfg_q <= 1'b0;
			fault_q <= 1'b0;
			pend_q <= PSAG_OP_NONE;
			pend_byte_q <= 1'b0;
			pend_bsel_q <= 1'b0;
		end else if (clk_en) begin
			addr_q <= mem_addr;
			rd_q <= do_read;
			cfg_q <= is_table && tpage_q[PSAG_PAGE_TOP];
			fault_q <= req_valid && over_user;
			pend_q <= do_read ? req_op : PSAG_OP_NONE;
			pend_byte_q <= req_byte;
			pend_bsel_q <= req_ea[0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fw_valid_q <= 1'b0;
			fw_high_q <= 1'b0;
			fw_addr_q <= 24'h000000;
			fw_data_q <= 16'h0000;
		end else if (clk_en) begin
			fw_valid_q <= do_flash;
			fw_high_q <= req_op == PSAG_OP_WR_HIGH;
			fw_addr_q <= mem_addr;
			fw_data_q <= req_wdata;
		end
	end

	// read data returns one cycle after pm_rd
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			instr_q <= 24'h000000;
			instr_v_q <= 1'b0;
			rdata_q <= 16'h0000;
			rd_v_q <= 1'b0;
		end else if (clk_en) begin
			instr_v_q <= pend_q == PSAG_OP_FETCH;
			if (pend_q == PSAG_OP_FETCH) begin
				instr_q <= pm_rdata;
			end
			rd_v_q <= (pend_q != PSAG_OP_FETCH) && (pend_q != PSAG_OP_NONE);
			if (pend_q == PSAG_OP_VIS) begin
				rdata_q <= pm_rdata[15:0];
			end else if (pend_q != PSAG_OP_NONE) begin
				rdata_q <= lane.data;
			end
		end
	end

	assign pc_out = pc_q;
	assign table_page_reg = tpage_q;
	assign visibility_page_reg = vpage_q;
	assign pm_addr = addr_q;
	assign pm_rd = rd_q;
	assign pm_config = cfg_q;
	assign addr_fault = fault_q;
	assign flash_wr_valid = fw_valid_q;
	assign flash_wr_high = fw_high_q;
	assign flash_wr_addr = fw_addr_q;
	assign flash_wr_data = fw_data_q;
	assign instr_word = instr_q;
	assign instr_valid = instr_v_q;
	assign rd_data = rdata_q;
	assign rd_valid = rd_v_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n || !clk_en);

	sequence s_fetch_req;
		req_valid && req_op == PSAG_OP_FETCH;
	endsequence
	sequence s_high_word;
		pend_q == PSAG_OP_RD_HIGH && !pend_byte_q;
	endsequence

	pc_step_two_a: assert property (
		pc_advance && !pc_load |=> pc_q == $past(pc_q) + PSAG_PC_STEP)
		else $error("pc did not step by two");
	fetch_addr_form_a: assert property (
		s_fetch_req |=> pm_addr[23] == 1'b0 && pm_addr[0] == 1'b0 && pm_rd)
		else $error("fetch address malformed");
	user_range_a: assert property (
		pm_rd && pm_addr > PSAG_USER_MAX |-> pm_config || pm_addr[23])
		else $error("user range exceeded");
	bit23_clear_a: assert property (
		req_valid && !is_table |=> !pm_addr[23])
		else $error("bit 23 set outside table access");
	config_space_a: assert property (
		req_valid && is_table |=> pm_config == $past(tpage_q[PSAG_PAGE_TOP]))
		else $error("config space select wrong");
	vis_addr_a: assert property (
		req_valid && is_vis |=> pm_addr[22:15] == $past(vpage_q))
		else $error("visibility page wrong");
	high_word_a: assert property (
		s_high_word |=> rd_valid && rd_data == {8'h00, $past(pm_rdata[23:16])})
		else $error("high word read wrong");
	flash_hand_a: assert property (
		req_valid && is_write |=> flash_wr_valid && !pm_rd)
		else $error("table write not handed to flash");
	high_byte_zero_a: assert property (
		is_high && pend_byte_q && pend_bsel_q |=> rd_data == 16'h0000)
		else $error("high byte select one not zero");
	// a frozen cycle must leave every strobe standing, neither repeated nor dropped
	freeze_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!clk_en |=> $stable(pc_q) && $stable(pm_rd) && $stable(rd_valid))
		else $error("state moved while clock enable low");
endmodule

// [testbench/psag_pmem_model.sv]
`timescale 1ns/100ps
module psag_pmem_model
	import psag_pkg::*;
(
	// clock
	input wire logic core_clk,
	// read port
	input wire logic [23:0] pm_addr,
	input wire logic pm_rd,
	output logic [23:0] pm_rdata
);
	logic [23:0] noise_q = 24'h000000;
	// contents follow the address, so the bench can predict every word
	function automatic logic [23:0] word_at(input logic [23:0] a);
		return {a[7:0] ^ 8'h5A, a[15:8], a[23:16] ^ 8'hC3};
	endfunction
	always @(posedge core_clk) begin
		noise_q <= noise_q + 24'h5A5A5B;
	end
	// the design samples data while pm_rd stands; off a read the bus changes every cycle
	assign pm_rdata = pm_rd ? word_at(pm_addr) : noise_q;
endmodule

// [testbench/program_space_address_gen_bench.sv]
`timescale 1ns/100ps
module program_space_address_gen_bench;
	import psag_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
	logic pc_advance = 1'b0, pc_load = 1'b0, table_page_we = 1'b0;
	logic visibility_page_we = 1'b0, program_visibility_enable = 1'b0;
	logic req_valid = 1'b0, req_byte = 1'b0;
	logic [22:0] pc_load_value = 23'h000000, pc_out, pc_m = 23'h000000;
	logic [7:0] table_page_wdata = 8'h00, visibility_page_wdata = 8'h00;
	logic [7:0] table_page_reg, visibility_page_reg, tp_m = 8'h00, vp_m = 8'h00;
	psag_op_t req_op = PSAG_OP_NONE;
	logic [15:0] req_ea = 16'h0000, req_wdata = 16'h0000, rd_data, flash_wr_data;
	logic [23:0] pm_addr, pm_rdata, flash_wr_addr, instr_word, a, w;
	logic pm_rd, pm_config, flash_wr_valid, flash_wr_high, instr_valid, rd_valid;
	logic addr_fault;
	logic [47:0] q_pm[$], q_ins[$], q_rd[$], q_fl[$];
	logic [47:0] e;
	logic [31:0] r;
	int seed, n_fail = 0, tests_run = 0, cyc = 0, i;
	psag_top i_dut (.core_clk, .rst_n, .clk_en, .pc_advance, .pc_load, .pc_load_value,
		.pc_out, .table_page_we, .table_page_wdata, .visibility_page_we,
		.visibility_page_wdata, .program_visibility_enable, .table_page_reg,
		.visibility_page_reg, .req_valid, .req_op, .req_ea, .req_byte, .pm_addr, .pm_rd,
		.pm_config, .pm_rdata, .flash_wr_valid, .flash_wr_high, .flash_wr_addr,
		.flash_wr_data, .req_wdata, .instr_word, .instr_valid, .rd_data, .rd_valid,
		.addr_fault);
	psag_pmem_model i_mem (.core_clk, .pm_addr, .pm_rd, .pm_rdata);
	always #5 core_clk = ~core_clk;
	task chk(input string n, input logic [47:0] exp, input logic [47:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", n, exp, got);
		end
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task house();
		r = $random(seed);
		req_valid = 1'b0;
		// about one house cycle in four is frozen, so the models must stand still too
		clk_en = r[6] | r[7];
		{pc_advance, pc_load, table_page_we, visibility_page_we} = {r[0], r[1] & r[2], r[4:3]};
		{pc_load_value, table_page_wdata} = {r[30:8], r[15:8]};
		{visibility_page_wdata, program_visibility_enable} = {r[23:16], r[5]};
		if (clk_en && pc_load)
			pc_m = pc_load_value & 23'h7FFFFE;
		else if (clk_en && pc_advance)
			pc_m = pc_m + PSAG_PC_STEP;
		if (clk_en && table_page_we)
			tp_m = table_page_wdata;
		if (clk_en && visibility_page_we)
			vp_m = visibility_page_wdata;
	endtask
	task issue();
		r = $random(seed);
		clk_en = 1'b1;
		{pc_advance, pc_load, table_page_we, visibility_page_we} = 4'h0;
		{req_valid, req_ea, req_byte, req_wdata} = {1'b1, r[23:8], r[4], r[31:16]};
		req_op = psag_op_t'(3'(r[2:0] % 3'd6) + 3'd1);
		if (req_op == PSAG_OP_FETCH)
			a = {1'b0, pc_m[22:1], 1'b0};
		else if (req_op == PSAG_OP_VIS)
			a = {1'b0, vp_m, req_ea[14:1], 1'b0};
		else
			a = {tp_m, req_ea[15:1], 1'b0};
		w = {a[7:0] ^ 8'h5A, a[15:8], a[23:16] ^ 8'hC3};
		if (req_op >= PSAG_OP_WR_LOW)
			q_fl.push_back({req_op == PSAG_OP_WR_HIGH, a[23:1], req_wdata});
		else if (req_op != PSAG_OP_VIS || (program_visibility_enable && req_ea[15])) begin
			q_pm.push_back({req_op >= PSAG_OP_RD_LOW && tp_m[7], a});
			if (req_op == PSAG_OP_FETCH)
				q_ins.push_back(w);
			else if (req_op == PSAG_OP_RD_HIGH)
				q_rd.push_back(req_byte ? {16'h00FF, 8'h00, req_ea[0] ? 8'h00 : w[23:16]}
					: {16'hFFFF, 8'h00, w[23:16]});
			else if (req_byte && req_op == PSAG_OP_RD_LOW)
				q_rd.push_back({16'h00FF, 8'h00, req_ea[0] ? w[15:8] : w[7:0]});
			else
				q_rd.push_back({16'hFFFF, w[15:0]});
		end
	endtask
	// strobes stand through a frozen cycle, so each is taken only after an enabled edge
	task observe();
		if (clk_en && pm_rd === 1'b1)
			chk("pm_addr", q_pm.pop_front(), {pm_config, pm_addr});
		if (clk_en && instr_valid === 1'b1)
			chk("instr_word", q_ins.pop_front(), instr_word);
		if (clk_en && rd_valid === 1'b1) begin
			e = q_rd.pop_front();
			chk("rd_data", e[15:0], rd_data & e[31:16]);
		end
		if (clk_en && flash_wr_valid === 1'b1) begin
			e = {flash_wr_high, flash_wr_addr[23:1], flash_wr_data};
			chk("flash", q_fl.pop_front(), e);
		end
		chk("pc_out", pc_m, pc_out);
		chk("pages", {tp_m, vp_m}, {table_page_reg, visibility_page_reg});
		chk("addr_fault", 0, addr_fault);
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 2000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		seed = 59;
		repeat (16) @(negedge core_clk);
		rst_n = 1'b1;
		// the last hundred requests come every cycle to run reads back to back
		for (i = 0; i < 600; i++) begin
			@(negedge core_clk);
			observe();
			if (i % 3 == 0 || i >= 500)
				issue();
			else
				house();
		end
		repeat (3) begin
			@(negedge core_clk);
			observe();
			req_valid = 1'b0;
		end
		chk("pending", 0, q_pm.size() + q_ins.size() + q_rd.size() + q_fl.size());
		complete_run();
	end
endmodule
